// ===== rtl/tpm_pkg.sv
// Constants, register map and field layout of the timer and period-measure unit.
// Assumes a single 125 MHz system clock and an Avalon-MM word-addressed register bus.
// What this block does
// - Prescaler, timers 1-3 count from first rising edge
// - Timer 4 counts after first falling edge
// - Edges before timer 1 runs are not counted
// - During measurement, flag marks completion, not underflow
// - Stopping measurement may set timer 1 flag
// - Control bit changes may set external 0 flag
// - Counter pins stay readable as inputs always
package tpm_pkg;
   // ==========================================================
   // Register byte offsets (one word each)
   localparam logic [5:0] OFF_CTRL      = 6'h00;
   localparam logic [5:0] OFF_SRC_SEL   = 6'h04;
   localparam logic [5:0] OFF_PRESCALER = 6'h08;
   localparam logic [5:0] OFF_TIMER0    = 6'h0C; // Timers 1..4 at +4 each
   localparam logic [5:0] OFF_RELOAD0   = 6'h1C; // Reloads 1..4 at +4 each
   localparam logic [5:0] OFF_T4_HIGH   = 6'h2C;
   localparam logic [5:0] OFF_FLAGS     = 6'h30;
   localparam logic [5:0] OFF_EXT0      = 6'h34;
   localparam logic [5:0] OFF_PINS      = 6'h38;
   localparam logic [5:0] OFF_CAPTURE   = 6'h3C;

   // ==========================================================
   // Control register fields
   localparam int CTRL_RUN0     = 0; // Bits 0..3 run timers 1..4
   localparam int CTRL_PRE_RUN  = 4;
   localparam int CTRL_MEAS_EN  = 5;
   localparam int CTRL_MEAS_SRC = 6; // 0 interrupt 0 pin, 1 counter pin 0
   localparam int CTRL_PWM_EXT  = 7;
   localparam int CTRL_PWM_OE   = 8;
   localparam int CTRL_W        = 9;

   // Flag register fields, write one to clear
   localparam int FLAG_T0       = 0; // Bits 0..3 timer request flags
   localparam int FLAG_EXT0     = 4;

   // Interrupt 0 control and key-on fields
   localparam int EXT_SYNC_SEL  = 0;
   localparam int EXT_POL       = 2; // 1 rising active, 0 falling active
   localparam int EXT_IN_EN     = 3;
   localparam int EXT_KEYON     = 4;

   // Count source codes
   localparam logic [1:0] SRC_PRESCALER = 2'h0;
   localparam logic [1:0] SRC_SYSCLK    = 2'h1; // System clock divided by two
   localparam logic [1:0] SRC_CNT0      = 2'h2;
   localparam logic [1:0] SRC_CNT1      = 2'h3;

   // Reset values
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [7:0] RST_RELOAD    = 8'hFF;
endpackage

// ===== rtl/tpm_tmr_if.sv
// Carrier between the unit's control logic and one 8-bit reload timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface tpm_tmr_if;
   logic       run;
   logic       tick;
   logic       load;
   logic [7:0] load_val;
   logic [7:0] reload_val;
   logic [7:0] count;
   logic       underflow;
   modport tmr (input run, tick, load, load_val, reload_val, output count, underflow);
   modport ctl (output run, tick, load, load_val, reload_val, input count, underflow);
endinterface
`default_nettype wire

// ===== rtl/tpm_timer.sv
// One 8-bit down counter with reload, driven by count ticks.
// Assumes ticks are already gated to the documented start edge.
`timescale 1ns/1ps
`default_nettype none
module tpm_timer
   import tpm_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   tpm_tmr_if.tmr    tif
);
   typedef struct packed {
      logic [7:0] count;
   } tpm_tmr_s;

   tpm_tmr_s st;
   tpm_tmr_s next_st;

   // ==========================================================
   // Underflow when a tick finds zero
   assign tif.underflow = tif.run & tif.tick & (st.count == RST_BYTE);
   assign tif.count     = st.count;

   // Load has priority; a load in the same cycle as a tick wins
   always_comb begin
      next_st = st;
      if (tif.load) begin
         next_st.count = tif.load_val;
      end else if (tif.underflow) begin
         next_st.count = tif.reload_val;
      end else if (tif.run & tif.tick) begin
         next_st.count = st.count - 8'h01;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '{count: RST_BYTE};
      end else begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/tpm_top.sv
// Prescaler, four reload timers, PWM on timer 4, period measurement on timer 1
// and the external 0 request flag, behind an Avalon-MM slave.
// Assumes pin inputs are synchronous to SYS_CLK_I.
`timescale 1ns/1ps
`default_nettype none
module tpm_top
   import tpm_pkg::*;
(
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic [3:0]  AVS_ADDRESS_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [31:0] AVS_WRITEDATA_I,
   output logic      [31:0] AVS_READDATA_O,
   output logic             AVS_WAITREQUEST_O,
   input  wire logic        COUNTER_PIN_ZERO_I,
   input  wire logic        COUNTER_PIN_ONE_I,
   output logic             COUNTER_PIN_ONE_O,
   output logic             COUNTER_PIN_ONE_OE_O,
   input  wire logic        EXT_IRQ_PIN_ZERO_I,
   output logic [3:0]       TIMER_REQUEST_O,
   output logic             EXT_ZERO_REQUEST_O
);
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [7:0]        src_sel;
      logic [7:0]        pre_reload;
      logic [7:0]        pre_cnt;
      logic [3:0][7:0]   reload;
      logic [7:0]        t4_high;
      logic [4:0]        flags;
      logic [4:0]        ext_ctrl;
      logic [3:0]        src_prev;
      logic              t4_armed;
      logic              pwm;
      logic              half_clk;
      logic              meas_prev;
      logic              meas_busy;
      logic [7:0]        capture;
      logic              ext_prev;
      logic              served;
      logic [31:0]       rdata;
   } tpm_top_s;

   tpm_top_s st;
   tpm_top_s next_st;
   logic     rst_meta;
   logic     rst_n;

   // ==========================================================
   // Reset release through two flops
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ==========================================================
   // Timers
   tpm_tmr_if tif [4] ();
   logic [3:0]       tick;
   logic [3:0]       load;
   logic [3:0][7:0]  load_val;
   logic [3:0][7:0]  reload_val;
   logic [3:0][7:0]  count;
   logic [3:0]       uflow;

   for (genvar g = 0; g < 4; g++) begin : g_tmr
      assign tif[g].run        = st.ctrl[CTRL_RUN0 + g];
      assign tif[g].tick       = tick[g];
      assign tif[g].load       = load[g];
      assign tif[g].load_val   = load_val[g];
      assign tif[g].reload_val = reload_val[g];
      assign count[g]          = tif[g].count;
      assign uflow[g]          = tif[g].underflow;
      tpm_timer u_tmr (
         .clk_i   (SYS_CLK_I),
         .rst_n_i (rst_n),
         .tif     (tif[g])
      );
   end

   // ==========================================================
   // Ports
   assign AVS_WAITREQUEST_O    = (AVS_READ_I | AVS_WRITE_I) & ~st.served;
   assign AVS_READDATA_O       = st.rdata;
   assign COUNTER_PIN_ONE_O    = st.pwm;
   assign COUNTER_PIN_ONE_OE_O = st.ctrl[CTRL_PWM_OE];
   assign TIMER_REQUEST_O      = st.flags[FLAG_T0 +: 4];
   assign EXT_ZERO_REQUEST_O   = st.flags[FLAG_EXT0];

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic       pre_tick;
      logic [3:0] lvl;
      logic       ext_act;
      logic       meas_lvl;
      logic       meas_edge;
      logic       wr;
      logic       rd;
      logic [5:0] off;
      logic [4:0] set_f;
      logic [4:0] clr_f;
      pre_tick  = 1'b0;
      lvl       = 4'h0;
      ext_act   = 1'b0;
      meas_lvl  = 1'b0;
      meas_edge = 1'b0;
      wr        = AVS_WRITE_I & st.served; // Lands where waitrequest is low
      rd        = AVS_READ_I & ~st.served;
      off       = {AVS_ADDRESS_I, 2'b00};
      set_f     = 5'h00;
      clr_f     = 5'h00;
      next_st   = st;
      tick      = 4'h0;
      load      = 4'h0;
      load_val  = '0;
      reload_val = st.reload;

      // One wait state per access; served is high for one cycle, then drops even if the request stays
      next_st.served   = (AVS_READ_I | AVS_WRITE_I) & ~st.served;
      next_st.half_clk = ~st.half_clk;

      // Prescaler runs on the system clock, underflow gives one tick
      if (st.ctrl[CTRL_PRE_RUN]) begin
         if (st.pre_cnt == RST_BYTE) begin
            pre_tick       = 1'b1;
            next_st.pre_cnt = st.pre_reload;
         end else begin
            next_st.pre_cnt = st.pre_cnt - 8'h01;
         end
      end

      // Source levels; ticks on rising edges so a level already high waits
      for (int i = 0; i < 4; i++) begin
         unique case (st.src_sel[2*i +: 2])
            SRC_PRESCALER: lvl[i] = pre_tick;
            SRC_SYSCLK:    lvl[i] = st.half_clk;
            SRC_CNT0:      lvl[i] = COUNTER_PIN_ZERO_I;
            SRC_CNT1:      lvl[i] = COUNTER_PIN_ONE_I;
         endcase
         tick[i] = lvl[i] & ~st.src_prev[i];
      end
      next_st.src_prev = lvl;

      // Timer 4 arms on the first falling edge after start
      if (!st.ctrl[CTRL_RUN0 + 3]) begin
         next_st.t4_armed = 1'b0;
      end else if (~lvl[3] & st.src_prev[3]) begin
         next_st.t4_armed = 1'b1;
      end
      tick[3] = tick[3] & st.t4_armed;

      // PWM toggles on timer 4 underflow; high interval may use its own reload
      if (~st.pwm & st.ctrl[CTRL_PWM_EXT]) begin
         reload_val[3] = st.t4_high;
      end
      if (uflow[3]) begin
         next_st.pwm = ~st.pwm;
      end

      // Underflow flags, except timer 1 while measuring
      set_f[3:0] = uflow;
      if (st.ctrl[CTRL_MEAS_EN]) begin
         set_f[0] = 1'b0;
      end

      // External 0 active level; gating and polarity changes can raise it
      ext_act = st.ext_ctrl[EXT_IN_EN] & ~(EXT_IRQ_PIN_ZERO_I ^ st.ext_ctrl[EXT_POL]);
      next_st.ext_prev = ext_act;
      set_f[FLAG_EXT0] = ext_act & ~st.ext_prev;

      // Period measurement on timer 1
      meas_lvl = st.ctrl[CTRL_MEAS_SRC] ? COUNTER_PIN_ZERO_I : ext_act;
      next_st.meas_prev = meas_lvl;
      meas_edge = meas_lvl & ~st.meas_prev & st.ctrl[CTRL_MEAS_EN] & st.ctrl[CTRL_RUN0];
      if (meas_edge) begin
         load[0]     = 1'b1;
         load_val[0] = st.reload[0];
         if (st.meas_busy) begin
            next_st.capture = count[0];
            set_f[0]        = 1'b1;
         end
         next_st.meas_busy = 1'b1;
      end
      if (!st.ctrl[CTRL_MEAS_EN]) begin
         next_st.meas_busy = 1'b0;
      end

      // Register writes
      if (wr) begin
         unique case (off)
            OFF_CTRL: begin
               next_st.ctrl = AVS_WRITEDATA_I[CTRL_W-1:0];
               if (st.ctrl[CTRL_MEAS_EN] & ~AVS_WRITEDATA_I[CTRL_MEAS_EN] & st.meas_busy) begin
                  set_f[0]          = 1'b1;
                  next_st.meas_busy = 1'b0;
               end
            end
            OFF_SRC_SEL:   next_st.src_sel = AVS_WRITEDATA_I[7:0];
            OFF_PRESCALER: begin
               next_st.pre_reload = AVS_WRITEDATA_I[7:0];
               next_st.pre_cnt    = AVS_WRITEDATA_I[7:0];
            end
            OFF_T4_HIGH:   next_st.t4_high  = AVS_WRITEDATA_I[7:0];
            OFF_FLAGS:     clr_f            = AVS_WRITEDATA_I[4:0];
            OFF_EXT0:      next_st.ext_ctrl = AVS_WRITEDATA_I[4:0];
            default: begin
               for (int i = 0; i < 4; i++) begin
                  if (off == OFF_TIMER0 + 6'(4 * i)) begin
                     load[i]     = 1'b1;
                     load_val[i] = AVS_WRITEDATA_I[7:0];
                  end
                  if (off == OFF_RELOAD0 + 6'(4 * i)) begin
                     next_st.reload[i] = AVS_WRITEDATA_I[7:0];
                  end
               end
            end
         endcase
      end

      // Flags: a hardware set wins over a software clear
      next_st.flags = (st.flags & ~clr_f) | set_f;

      // Read data captured in the wait cycle
      if (rd) begin
         next_st.rdata = 32'h0000_0000;
         unique case (off)
            OFF_CTRL:      next_st.rdata[CTRL_W-1:0] = st.ctrl;
            OFF_SRC_SEL:   next_st.rdata[7:0] = st.src_sel;
            OFF_PRESCALER: next_st.rdata[7:0] = st.pre_cnt;
            OFF_T4_HIGH:   next_st.rdata[7:0] = st.t4_high;
            OFF_FLAGS:     next_st.rdata[4:0] = st.flags;
            OFF_EXT0:      next_st.rdata[4:0] = st.ext_ctrl;
            OFF_PINS:      next_st.rdata[2:0] = {EXT_IRQ_PIN_ZERO_I, COUNTER_PIN_ONE_I,
                                                 COUNTER_PIN_ZERO_I};
            OFF_CAPTURE:   next_st.rdata[7:0] = st.capture;
            default: begin
               for (int i = 0; i < 4; i++) begin
                  if (off == OFF_TIMER0 + 6'(4 * i)) begin
                     next_st.rdata[7:0] = count[i];
                  end
                  if (off == OFF_RELOAD0 + 6'(4 * i)) begin
                     next_st.rdata[7:0] = st.reload[i];
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         st         <= '0;
         st.reload  <= {4{RST_RELOAD}};
         st.t4_high <= RST_RELOAD;
      end else begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

// ===== bench/tpm_top_chk.sv
// Port checker for tpm_top, bound to every instance.
// Assumes the single clock and the raw reset of the top.
`timescale 1ns/1ps
`default_nettype none
module tpm_top_chk
   import tpm_pkg::*;
(
   input wire logic        SYS_CLK_I,
   input wire logic        RST_N_I,
   input wire logic [3:0]  AVS_ADDRESS_I,
   input wire logic        AVS_READ_I,
   input wire logic        AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [31:0] AVS_READDATA_O,
   input wire logic        AVS_WAITREQUEST_O,
   input wire logic        COUNTER_PIN_ZERO_I,
   input wire logic        COUNTER_PIN_ONE_I,
   input wire logic        COUNTER_PIN_ONE_O,
   input wire logic        COUNTER_PIN_ONE_OE_O,
   input wire logic        EXT_IRQ_PIN_ZERO_I,
   input wire logic [3:0]  TIMER_REQUEST_O,
   input wire logic        EXT_ZERO_REQUEST_O
);
   logic       wr;
   logic       wr0;
   logic       act;
   logic [2:0] pins;
   logic [8:0] ctl;
   logic [4:0] ext;
   // ==========================================
   // Shadows of control words, taken where the slave takes a write
   assign wr   = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
   assign wr0  = wr & (AVS_ADDRESS_I == OFF_CTRL[5:2]);
   assign act  = ext[EXT_IN_EN] & (EXT_IRQ_PIN_ZERO_I == ext[EXT_POL]);
   assign pins = {EXT_IRQ_PIN_ZERO_I, COUNTER_PIN_ONE_I, COUNTER_PIN_ZERO_I};
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ctl <= 9'h000;
         ext <= 5'h00;
      end else if (wr0) begin
         ctl <= AVS_WRITEDATA_I[8:0];
      end else if (wr && AVS_ADDRESS_I == OFF_EXT0[5:2]) begin
         ext <= AVS_WRITEDATA_I[4:0];
      end
   end
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // ==========================================
   // Handshake, sticky flags, flag causes and pin reads
   a_wait_first: assert property ($rose(AVS_READ_I | AVS_WRITE_I) |-> AVS_WAITREQUEST_O)
      else $error("waitrequest low in first cycle");
   a_wait_second: assert property ((AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
      else $error("second wait state");
   a_oe_follow: assert property (wr0 |-> ##[1:2] COUNTER_PIN_ONE_OE_O == ctl[CTRL_PWM_OE])
      else $error("output enable not from control");
   a_flag_sticky: assert property (|($past(TIMER_REQUEST_O) & ~TIMER_REQUEST_O) |->
      $past(wr) && $past(AVS_ADDRESS_I) == OFF_FLAGS[5:2]) else $error("timer flag lost");
   a_ext_sticky: assert property ($fell(EXT_ZERO_REQUEST_O) |->
      $past(wr) && $past(AVS_ADDRESS_I) == OFF_FLAGS[5:2]) else $error("ext flag lost");
   a_ext_set: assert property ($rose(act) |-> ##[1:4] EXT_ZERO_REQUEST_O)
      else $error("ext flag not set");
   a_idle_quiet: assert property ($rose(TIMER_REQUEST_O[0]) |-> $past(ctl[0]) || $past(wr0))
      else $error("timer 1 flag while stopped");
   a_pin_read: assert property (AVS_READ_I && !AVS_WAITREQUEST_O &&
      AVS_ADDRESS_I == OFF_PINS[5:2] |-> AVS_READDATA_O[2:0] == $past(pins)) else $error("pin read");
   a_pwm_on_uflow: assert property ($changed(COUNTER_PIN_ONE_O) |-> TIMER_REQUEST_O[3])
      else $error("PWM toggled without timer 4 underflow");
endmodule
bind tpm_top tpm_top_chk tpm_top_chk_inst (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
   .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
   .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
   .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .COUNTER_PIN_ZERO_I(COUNTER_PIN_ZERO_I),
   .COUNTER_PIN_ONE_I(COUNTER_PIN_ONE_I), .COUNTER_PIN_ONE_O(COUNTER_PIN_ONE_O),
   .COUNTER_PIN_ONE_OE_O(COUNTER_PIN_ONE_OE_O),
   .EXT_IRQ_PIN_ZERO_I(EXT_IRQ_PIN_ZERO_I), .TIMER_REQUEST_O(TIMER_REQUEST_O),
   .EXT_ZERO_REQUEST_O(EXT_ZERO_REQUEST_O));
`default_nettype wire

// ===== bench/tpm_pulse_src.sv
// Measured square wave at the interrupt 0 pin.
// Assumes the bench clock; low while disabled.
`timescale 1ns/1ps
`default_nettype none
module tpm_pulse_src (
   input  wire logic       clk_i,
   input  wire logic       en_i,
   input  wire logic [7:0] half_i,
   output logic            pulse_o
);
   logic [7:0] cnt = 8'h00;
   initial pulse_o = 1'b0;
   // Half period of half_i+1 clocks, far slower than timer 1 ticks
   always @(posedge clk_i) begin
      if (!en_i || cnt == half_i) begin
         cnt     <= 8'h00;
         pulse_o <= en_i & ~pulse_o;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ===== bench/tpm_top_tb.sv
// Self-checking bench for tpm_top with a pulse source at the pin.
// Assumes the bound checker; reads are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module tpm_top_tb
   import tpm_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata;
   logic        waitreq;
   logic        cnt0 = 1'b0;
   logic        cnt1 = 1'b0;
   logic        ext_lvl = 1'b0;
   logic        meas_on = 1'b0;
   logic        pulse;
   logic [7:0]  rl;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          cyc = 0;
   always #4 clk = ~clk;
   tpm_top tpm_top_inst (.SYS_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
      .COUNTER_PIN_ZERO_I(cnt0), .COUNTER_PIN_ONE_I(cnt1), .COUNTER_PIN_ONE_O(),
      .COUNTER_PIN_ONE_OE_O(), .EXT_IRQ_PIN_ZERO_I(meas_on ? pulse : ext_lvl),
      .TIMER_REQUEST_O(), .EXT_ZERO_REQUEST_O());
   tpm_pulse_src tpm_pulse_src_inst (.clk_i(clk), .en_i(meas_on), .half_i(8'h15), .pulse_o(pulse));
   // ==========================================
   // Bus cycle; request held until waitrequest is seen low
   task automatic bus(input logic [5:0] off, input logic w, input logic [31:0] d);
      @(posedge clk);
      addr <= off[5:2];
      rd   <= ~w;
      wr   <= w;
      wd   <= d;
      // Waitrequest seen as it stood before each rising edge
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdchk(input logic [5:0] off, input logic [31:0] e, input logic [31:0] m = '1);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(off, 1'b0, 32'h0);
   endtask
   // One rising and one falling edge on counter pin 1
   task automatic edge1();
      @(posedge clk) cnt1 <= 1'b1;
      repeat (3) @(posedge clk);
      cnt1 <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Read data taken at the edge where waitrequest is low
   always @(posedge clk) begin
      if (rd && waitreq === 1'b0) begin
         samples_checked++;
         if ((rdata & msk_q[0]) !== (exp_q[0] & msk_q[0])) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, rdata & msk_q[0], exp_q[0]);
         end
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   // Hang guard, far above the length of the sequence
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // ==========================================
   initial begin
      void'($urandom(81));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdchk(OFF_CTRL, 32'h0);
      for (int i = 0; i < 4; i++) rdchk(OFF_RELOAD0 + 6'(4 * i), {24'h0, RST_RELOAD});
      bus(OFF_PRESCALER, 1'b1, 32'h3);
      rdchk(OFF_PRESCALER, 32'h3, 32'hFF);
      bus(OFF_SRC_SEL, 1'b1, 32'hFF);
      bus(OFF_CTRL, 1'b1, 32'h100);
      // Pins stay readable with counter functions selected
      for (int i = 0; i < 4; i++) begin
         rl = 8'($urandom);
         {ext_lvl, cnt1, cnt0} <= rl[2:0];
         rdchk(OFF_PINS, {29'h0, rl[2:0]}, 32'h7);
      end
      cnt1 <= 1'b0;
      rl = 8'($urandom_range(255, 3));
      for (int i = 0; i < 4; i++) begin
         bus(OFF_TIMER0 + 6'(4 * i), 1'b1, 32'h2);
         bus(OFF_RELOAD0 + 6'(4 * i), 1'b1, {24'h0, rl});
      end
      // Timer 4 skips the first rising edge after start
      bus(OFF_CTRL, 1'b1, 32'hF);
      repeat (3) edge1();
      bus(OFF_CTRL, 1'b1, 32'h0);
      rdchk(OFF_FLAGS, 32'h7, 32'hF);
      rdchk(OFF_TIMER0, {24'h0, rl});
      rdchk(OFF_TIMER0 + 6'hC, 32'h0, 32'hFF);
      // High interval reload used on the first PWM underflow
      bus(OFF_T4_HIGH, 1'b1, 32'h5A);
      bus(OFF_CTRL, 1'b1, 32'h88);
      repeat (2) edge1();
      bus(OFF_CTRL, 1'b1, 32'h0);
      rdchk(OFF_FLAGS, 32'hF, 32'hF);
      rdchk(OFF_TIMER0 + 6'hC, 32'h5A, 32'hFF);
      bus(OFF_FLAGS, 1'b1, 32'h1F);
      rdchk(OFF_FLAGS, 32'h0, 32'hF);
      // External 0 flag from control writes against the pin level
      ext_lvl <= 1'b1;
      bus(OFF_EXT0, 1'b1, 32'h4);
      bus(OFF_FLAGS, 1'b1, 32'h10);
      rdchk(OFF_FLAGS, 32'h0, 32'h10);
      bus(OFF_EXT0, 1'b1, 32'hC);
      rdchk(OFF_FLAGS, 32'h10, 32'h10);
      bus(OFF_FLAGS, 1'b1, 32'h10);
      bus(OFF_EXT0, 1'b1, 32'h8);
      bus(OFF_EXT0, 1'b1, 32'hC);
      rdchk(OFF_FLAGS, 32'h10, 32'h10);
      // Period measurement, timer 1 at half rate, source kept off pin 0
      ext_lvl <= 1'b0;
      bus(OFF_EXT0, 1'b1, 32'h8);
      bus(OFF_SRC_SEL, 1'b1, 32'h1);
      bus(OFF_TIMER0, 1'b1, 32'hFF);
      bus(OFF_RELOAD0, 1'b1, 32'hFF);
      bus(OFF_FLAGS, 1'b1, 32'h1F);
      bus(OFF_CTRL, 1'b1, 32'h20);
      meas_on <= 1'b1;
      repeat (150) @(posedge clk);
      rdchk(OFF_FLAGS, 32'h0, 32'h1);
      rdchk(OFF_TIMER0, 32'hFF, 32'hFF);
      bus(OFF_CTRL, 1'b1, 32'h21);
      repeat (150) @(posedge clk);
      {meas_on, ext_lvl} <= 2'b01; // Pin parked inactive, no stray edge
      rdchk(OFF_FLAGS, 32'h1, 32'h1);
      rdchk(OFF_CAPTURE, 32'hE8, 32'hFC);
      bus(OFF_FLAGS, 1'b1, 32'h1F);
      rdchk(OFF_FLAGS, 32'h0, 32'h1);
      bus(OFF_CTRL, 1'b1, 32'h1);
      rdchk(OFF_FLAGS, 32'h1, 32'h1);
      bus(OFF_CTRL, 1'b1, 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
